// ===== dfm_pkg.sv
package dfm_pkg;
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned VX_HOLD_MS      = 300;
  localparam int unsigned STILL_ON_MS     = 5000;
  localparam int unsigned REGEN_START_MS  = 1000;
  localparam int unsigned VX_HOLD_CYC     = (CLK_HZ / 1000) * VX_HOLD_MS;
  localparam int unsigned STILL_ON_CYC    = (CLK_HZ / 1000) * STILL_ON_MS;
  localparam int unsigned REGEN_START_CYC = (CLK_HZ / 1000) * REGEN_START_MS;

  // Word byte addresses of the register map.
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_CDLY      = 8'h04;
  localparam logic [7:0] ADDR_IMAX      = 8'h08;
  localparam logic [7:0] ADDR_TMAX      = 8'h0C;
  localparam logic [7:0] ADDR_VZ        = 8'h10;
  localparam logic [7:0] ADDR_ERR       = 8'h14;
  localparam logic [7:0] ADDR_ACK       = 8'h18;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h1C;
  localparam logic [7:0] ADDR_IRQ_EN    = 8'h20;
  localparam logic [7:0] ADDR_IRQ_CLR   = 8'h24;
  localparam logic [7:0] ADDR_STATUS    = 8'h28;

  // Control register fields.
  localparam int unsigned CTRL_LOCK_BIT    = 0;
  localparam int unsigned CTRL_MASK560_BIT = 1;
  localparam int unsigned CTRL_OPEN_M_BIT  = 2;
  localparam int unsigned CTRL_CFG_LSB     = 8;
  localparam int unsigned CTRL_CFG_W       = 8;
  localparam logic [7:0] CFG_TERMINAL_IO   = 8'h1F;

  // Error numbers; all but 570 are reported in the error register.
  localparam logic [9:0] ERR_CO_ON         = 10'd540;
  localparam logic [9:0] ERR_VX_ACTIVE     = 10'd544;
  localparam logic [9:0] ERR_OPEN_EARLY    = 10'd545;
  localparam logic [9:0] ERR_OPEN_EARLY_M  = 10'd546;
  localparam logic [9:0] ERR_CO1_STILL     = 10'd548;
  localparam logic [9:0] ERR_CO12_STILL    = 10'd549;
  localparam logic [9:0] ERR_OVERLOAD      = 10'd550;
  localparam logic [9:0] ERR_READJ_SPEED   = 10'd560;
  localparam logic [9:0] ERR_REGEN_FAULT   = 10'd570;
  localparam logic [9:0] ERR_REGEN_STDBY   = 10'd571;

  // Interrupt status bit positions.
  localparam int unsigned IRQ_ERR_BIT   = 0;
  localparam int unsigned IRQ_REGEN_BIT = 1;
  localparam int unsigned IRQ_LOCK_BIT  = 2;
  localparam int unsigned IRQ_W         = 3;

  localparam logic [15:0] CDLY_RESET = 16'h00_C8;
  localparam logic [15:0] TMAX_RESET = 16'h03_E8;
endpackage

// ===== dfm_tick_if.sv
`timescale 1ns/1ps
interface dfm_tick_if;
  logic ms_tick;
  modport src (output ms_tick);
  modport dst (input  ms_tick);
endinterface

// ===== dfm_ms_timer.sv
`timescale 1ns/1ps
module dfm_ms_timer #(
  parameter int unsigned CYC_PER_MS = dfm_pkg::CLK_HZ / 1000
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  dfm_tick_if.src   tick
);
  initial begin
    if (CYC_PER_MS < 1) $error("CYC_PER_MS must be at least one");
  end

  logic [31:0] cnt_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i || cnt_reg == 32'(CYC_PER_MS - 1)) begin
      cnt_reg <= 32'h0000_0000;
    end else begin
      cnt_reg <= cnt_reg + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick.ms_tick <= 1'b0;
    end else begin
      tick.ms_tick <= (cnt_reg == 32'(CYC_PER_MS - 1));
    end
  end
endmodule

// ===== dfm_monitor.sv
// Our own choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
// Contract
// - Contactor check delay expires without any feedback: error 540.
// - Contactor errors carry info code 1, 2 or 3 for failing inputs.
// - Travel commands active 300 ms after status outputs drop: error 544.
// - Only one contactor open during travel: error 545, or 546 in the other variant.
// - 5 s after check delay, only first still on: 548; second or both still on: 549.
// - Current above maximum for the overload time limit: error 550.
// - Speed above readjust limit while readjusting: error 560.
// - With lock-on-error set, error 560 locks the drive.
// - Error 560 reported only if masked in; terminal config 31 enables it.
// - Feedback unit monitor contact opens while operating: error 570.
// - Error 570 clears itself when the monitor contact closes again.
// - Feedback unit not active 1 s after travel start: error 571.
module dfm_monitor #(
  parameter int unsigned CYC_PER_MS = dfm_pkg::CLK_HZ / 1000,
  parameter int unsigned VX_MS      = dfm_pkg::VX_HOLD_MS,
  parameter int unsigned STILL_MS   = dfm_pkg::STILL_ON_MS,
  parameter int unsigned REGEN_MS   = dfm_pkg::REGEN_START_MS
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        contactor_feedback_first_i,
  input  wire logic        contactor_feedback_second_i,
  input  wire logic        contactors_commanded_i,
  input  wire logic        travel_active_i,
  input  wire logic        travel_cmd_i,
  input  wire logic        drive_release_signal_i,
  input  wire logic        readjust_i,
  input  wire logic [15:0] motor_current_i,
  input  wire logic [15:0] actual_speed_i,
  input  wire logic        drive_operating_i,
  input  wire logic        regen_monitor_closed_i,
  input  wire logic        regen_active_i,
  output logic             drive_status_output_one_o,
  output logic             drive_status_output_two_o,
  output logic             locked_o,
  output logic             irq_o
);
  // The ms counters are 16 bits wide, the drop-out count 17; a longer time would wrap and never expire.
  initial begin
    if (CYC_PER_MS < 1) $error("CYC_PER_MS must be at least one");
    if (VX_MS < 1 || VX_MS > 65535) $error("VX_MS out of range");
    if (STILL_MS < 1 || STILL_MS > 65535) $error("STILL_MS out of range");
    if (REGEN_MS < 1 || REGEN_MS > 65535) $error("REGEN_MS out of range");
  end

  dfm_tick_if tick_bus ();

  dfm_ms_timer #(
    .CYC_PER_MS (CYC_PER_MS)
  ) u_timer (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .tick  (tick_bus)
  );

  // One-cycle pulse every millisecond; every supervision time counts these pulses.
  wire logic ms = tick_bus.ms_tick;

  logic [31:0] ctrl_reg;
  logic [15:0] contactor_check_delay_reg;
  logic [15:0] imax_reg;
  logic [15:0] tmax_reg;
  logic [15:0] readjust_speed_limit_reg;
  logic [9:0]  err_num_reg;
  logic [1:0]  err_info_reg;
  logic        err_valid_reg;
  logic        regen_fault_reg;
  logic [dfm_pkg::IRQ_W-1:0] irq_stat_reg;
  logic [dfm_pkg::IRQ_W-1:0] irq_en_reg;

  logic [15:0] cdly_cnt_reg;
  logic        cdly_done_reg;
  logic [16:0] still_cnt_reg;
  logic        still_done_reg;
  logic [15:0] vx_cnt_reg;
  logic        vx_run_reg;
  logic [15:0] ovl_cnt_reg;
  logic [15:0] regen_cnt_reg;
  logic        travel_q_reg;
  logic        status_q_reg;

  wire logic bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire logic bus_wr  = bus_req && wb_we_i && wb_sel_i[0];
  // Second over first, so the packed value doubles as the info code weights.
  wire logic [1:0] co_bits = {contactor_feedback_second_i, contactor_feedback_first_i};
  wire logic [7:0] terminal_io_config = ctrl_reg[dfm_pkg::CTRL_CFG_LSB +: dfm_pkg::CTRL_CFG_W];
  // The terminal configuration forces the mask on without touching the stored bit.
  wire logic mask560 = ctrl_reg[dfm_pkg::CTRL_MASK560_BIT]
                     || terminal_io_config == dfm_pkg::CFG_TERMINAL_IO;
  wire logic ack_wr = bus_wr && wb_adr_i == dfm_pkg::ADDR_ACK;

  // Error events, highest priority first in the chain below.
  wire logic ev540 = contactors_commanded_i && cdly_done_reg && co_bits == 2'b00;
  wire logic ev54x = travel_active_i && contactors_commanded_i && cdly_done_reg
                   && co_bits != 2'b11;
  wire logic ev549 = !contactors_commanded_i && still_done_reg && co_bits != 2'b00;
  wire logic ev544 = vx_run_reg && ms && vx_cnt_reg == 16'(VX_MS - 1) && travel_cmd_i;
  wire logic ev550 = ms && ovl_cnt_reg == tmax_reg && motor_current_i > imax_reg;
  wire logic ev560 = readjust_i && actual_speed_i > readjust_speed_limit_reg && mask560;
  wire logic ev571 = travel_active_i && !regen_active_i && ms
                   && regen_cnt_reg == 16'(REGEN_MS - 1);
  wire logic any_ev = ev540 | ev54x | ev549 | ev544 | ev550 | ev560 | ev571;

  // Status outputs drop on release loss or when the contactors fall away in travel.
  wire logic status_on = drive_release_signal_i && !(travel_active_i && ev54x);

  // Both outputs follow one condition; a lock holds them off until reset.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drive_status_output_one_o <= 1'b0;
      drive_status_output_two_o <= 1'b0;
      status_q_reg              <= 1'b0;
      travel_q_reg              <= 1'b0;
    end else begin
      drive_status_output_one_o <= status_on && !locked_o;
      drive_status_output_two_o <= status_on && !locked_o;
      status_q_reg              <= status_on;
      travel_q_reg              <= travel_active_i;
    end
  end

  // Contactor check delay runs while contactors are commanded, in ms.
  // A rewrite of the delay register takes effect on a count that is already running.
  always_ff @(posedge clk_i) begin
    if (rst_i || !contactors_commanded_i) begin
      cdly_cnt_reg  <= 16'h0000;
      cdly_done_reg <= 1'b0;
    end else if (ms && !cdly_done_reg) begin
      if (cdly_cnt_reg >= contactor_check_delay_reg) begin
        cdly_done_reg <= 1'b1;
      end else begin
        cdly_cnt_reg <= cdly_cnt_reg + 16'h0001;
      end
    end
  end

  // Drop-out check: the delay is counted again after command removal, then 5 s.
  // The sum needs 17 bits: a long check delay plus 5 s would wrap a 16-bit count.
  always_ff @(posedge clk_i) begin
    if (rst_i || contactors_commanded_i) begin
      still_cnt_reg  <= 17'h0_0000;
      still_done_reg <= 1'b0;
    end else if (ms && !still_done_reg) begin
      if (still_cnt_reg >= 17'(STILL_MS) + {1'b0, contactor_check_delay_reg}) begin
        still_done_reg <= 1'b1;
      end else begin
        still_cnt_reg <= still_cnt_reg + 17'h0_0001;
      end
    end
  end

  // Falling status outputs open the window; a command still on at its end is an error.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vx_run_reg <= 1'b0;
      vx_cnt_reg <= 16'h0000;
    end else if (status_q_reg && !status_on) begin
      vx_run_reg <= 1'b1;
      vx_cnt_reg <= 16'h0000;
    end else if (vx_run_reg && ms) begin
      if (vx_cnt_reg == 16'(VX_MS - 1)) begin
        vx_run_reg <= 1'b0;
      end
      vx_cnt_reg <= vx_cnt_reg + 16'h0001;
    end
  end

  // Overload time restarts whenever the current falls back to the limit or below.
  always_ff @(posedge clk_i) begin
    if (rst_i || motor_current_i <= imax_reg) begin
      ovl_cnt_reg <= 16'h0000;
    end else if (ms && ovl_cnt_reg != tmax_reg) begin
      ovl_cnt_reg <= ovl_cnt_reg + 16'h0001;
    end
  end

  // The standby window restarts on every new travel, so no time carries over.
  always_ff @(posedge clk_i) begin
    if (rst_i || !travel_active_i || (travel_active_i && !travel_q_reg)) begin
      regen_cnt_reg <= 16'h0000;
    end else if (ms && regen_cnt_reg != 16'(REGEN_MS - 1)) begin
      regen_cnt_reg <= regen_cnt_reg + 16'h0001;
    end
  end

  // First error is kept; acknowledge frees the slot, a same-cycle event wins.
  // A condition that persists is raised again right after the acknowledge.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_valid_reg <= 1'b0;
      err_num_reg   <= 10'd0;
      err_info_reg  <= 2'd0;
    end else if (any_ev && (!err_valid_reg || ack_wr)) begin
      err_valid_reg <= 1'b1;
      err_info_reg  <= 2'd0;
      if (ev540) begin
        err_num_reg  <= dfm_pkg::ERR_CO_ON;
        err_info_reg <= 2'b11;
      end else if (ev54x) begin
        err_num_reg  <= ctrl_reg[dfm_pkg::CTRL_OPEN_M_BIT] ? dfm_pkg::ERR_OPEN_EARLY_M
                                                          : dfm_pkg::ERR_OPEN_EARLY;
        err_info_reg <= ~co_bits;
      end else if (ev549) begin
        err_num_reg  <= (co_bits == 2'b01) ? dfm_pkg::ERR_CO1_STILL
                                           : dfm_pkg::ERR_CO12_STILL;
        err_info_reg <= co_bits;
      end else if (ev544) begin
        err_num_reg <= dfm_pkg::ERR_VX_ACTIVE;
      end else if (ev550) begin
        err_num_reg <= dfm_pkg::ERR_OVERLOAD;
      end else if (ev560) begin
        err_num_reg <= dfm_pkg::ERR_READJ_SPEED;
      end else begin
        err_num_reg <= dfm_pkg::ERR_REGEN_STDBY;
      end
    end else if (ack_wr) begin
      err_valid_reg <= 1'b0;
    end
  end

  // This fault has no slot and needs no acknowledge; it follows the contact.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      regen_fault_reg <= 1'b0;
    end else if (drive_operating_i && !regen_monitor_closed_i) begin
      regen_fault_reg <= 1'b1;
    end else if (regen_monitor_closed_i) begin
      regen_fault_reg <= 1'b0;
    end
  end

  // Lock is left only by reset; it gates the status outputs.
  // Only the readjust overspeed locks; other errors except 545/546, and 540 in travel, leave the outputs to the release.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      locked_o <= 1'b0;
    end else if (ev560 && ctrl_reg[dfm_pkg::CTRL_LOCK_BIT]) begin
      locked_o <= 1'b1;
    end
  end

  wire logic [dfm_pkg::IRQ_W-1:0] irq_ev = {ev560 && ctrl_reg[dfm_pkg::CTRL_LOCK_BIT],
                                            drive_operating_i && !regen_monitor_closed_i,
                                            any_ev};
  wire logic irq_clr_wr = bus_wr && wb_adr_i == dfm_pkg::ADDR_IRQ_CLR;

  // An event in the same cycle as a clear keeps its bit set, so no event is lost.
  genvar gi;
  generate
    for (gi = 0; gi < dfm_pkg::IRQ_W; gi++) begin : g_irq
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          irq_stat_reg[gi] <= 1'b0;
        end else if (irq_ev[gi]) begin
          irq_stat_reg[gi] <= 1'b1;
        end else if (irq_clr_wr && wb_dat_i[gi]) begin
          irq_stat_reg[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Registered so the pin cannot glitch while status and enable change together.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat_reg & irq_en_reg);
    end
  end

  // Writes to configuration registers; full word, only lane 0 qualifies.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg                  <= 32'h0000_0000;
      contactor_check_delay_reg <= dfm_pkg::CDLY_RESET;
      imax_reg                  <= 16'hFFFF;
      tmax_reg                  <= dfm_pkg::TMAX_RESET;
      readjust_speed_limit_reg  <= 16'hFFFF;
      irq_en_reg                <= '0;
    end else if (bus_wr) begin
      if (wb_adr_i == dfm_pkg::ADDR_CTRL) begin
        ctrl_reg <= wb_dat_i;
      end else if (wb_adr_i == dfm_pkg::ADDR_CDLY) begin
        contactor_check_delay_reg <= wb_dat_i[15:0];
      end else if (wb_adr_i == dfm_pkg::ADDR_IMAX) begin
        imax_reg <= wb_dat_i[15:0];
      end else if (wb_adr_i == dfm_pkg::ADDR_TMAX) begin
        tmax_reg <= wb_dat_i[15:0];
      end else if (wb_adr_i == dfm_pkg::ADDR_VZ) begin
        readjust_speed_limit_reg <= wb_dat_i[15:0];
      end else if (wb_adr_i == dfm_pkg::ADDR_IRQ_EN) begin
        irq_en_reg <= wb_dat_i[dfm_pkg::IRQ_W-1:0];
      end
    end
  end

  // Reads have no side effects, so the mux may follow the address before a request.
  logic [31:0] rd_data;
  always_comb begin
    rd_data = 32'h0000_0000;
    if (wb_adr_i == dfm_pkg::ADDR_CTRL) begin
      rd_data = {ctrl_reg[31:2], mask560, ctrl_reg[0]};
    end else if (wb_adr_i == dfm_pkg::ADDR_CDLY) begin
      rd_data = {16'h0000, contactor_check_delay_reg};
    end else if (wb_adr_i == dfm_pkg::ADDR_IMAX) begin
      rd_data = {16'h0000, imax_reg};
    end else if (wb_adr_i == dfm_pkg::ADDR_TMAX) begin
      rd_data = {16'h0000, tmax_reg};
    end else if (wb_adr_i == dfm_pkg::ADDR_VZ) begin
      rd_data = {16'h0000, readjust_speed_limit_reg};
    end else if (wb_adr_i == dfm_pkg::ADDR_ERR) begin
      rd_data = {err_valid_reg, 17'h0_0000, err_info_reg, 2'b00, err_num_reg};
    end else if (wb_adr_i == dfm_pkg::ADDR_IRQ_STAT) begin
      rd_data = {29'h0000_0000, irq_stat_reg};
    end else if (wb_adr_i == dfm_pkg::ADDR_IRQ_EN) begin
      rd_data = {29'h0000_0000, irq_en_reg};
    end else if (wb_adr_i == dfm_pkg::ADDR_STATUS) begin
      rd_data = {28'h000_0000, locked_o, regen_fault_reg, co_bits};
    end
  end

  // Ack is suppressed while high, so each request is answered exactly once.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? rd_data : 32'h0000_0000;
    end
  end
endmodule

// ===== dfm_monitor_chk.sv
`timescale 1ns/1ps
module dfm_monitor_chk (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic        wb_we_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        drive_release_signal_i,
  input wire logic        drive_status_output_one_o,
  input wire logic        drive_status_output_two_o,
  input wire logic        locked_o,
  input wire logic        irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered in one cycle");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");
  a_dead_read: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h28 |-> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_status_pair: assert property (drive_status_output_one_o == drive_status_output_two_o)
    else $error("status outputs differ");
  a_status_release: assert property (!drive_release_signal_i |-> ##[1:2] !drive_status_output_one_o)
    else $error("status output stays on without release");
  a_lock_sticky: assert property (locked_o |=> locked_o)
    else $error("lock dropped without reset");
  a_lock_drops: assert property (locked_o |-> ##[1:2] !drive_status_output_two_o)
    else $error("status output on while locked");

  c_lock: cover property ($rose(locked_o));
  c_irq: cover property ($rose(irq_o));
  c_write: cover property (wb_ack_o && wb_we_i);
endmodule

// ===== dfm_plant_model.sv
`timescale 1ns/1ps
module dfm_plant_model (
  input  wire logic       clk_i,
  input  wire logic       cmd_i,
  input  wire logic       travel_i,
  input  wire logic [1:0] open_i,
  input  wire logic [1:0] stuck_i,
  input  wire logic       regen_open_i,
  input  wire logic       regen_fail_i,
  output logic      [1:0] feedback_o,
  output logic            regen_closed_o,
  output logic            regen_active_o
);
  // A broken coil never closes and a welded contact never drops, which is
  // exactly what the supervision has to notice.
  always_ff @(posedge clk_i) begin
    feedback_o     <= ({2{cmd_i}} & ~open_i) | stuck_i;
    regen_closed_o <= !regen_open_i;
    regen_active_o <= travel_i && !regen_fail_i;
  end
endmodule

// ===== dfm_monitor_tb_top.sv
`timescale 1ns/1ps
module dfm_monitor_tb_top;
  localparam int MS = 4;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wd = 32'h0000_0000;
  logic [31:0] rdo, rq;
  logic        we = 1'b0, cyc = 1'b0, stb = 1'b0, ack, cmd = 1'b0, trav = 1'b0;
  logic        tcmd = 1'b0, rel = 1'b0, readj = 1'b0, oper = 1'b0, ropen = 1'b0;
  logic        rfail = 1'b0, out1, out2, lck, irq, rcl, ract;
  logic [1:0]  opn = 2'b00, stk = 2'b00, fb;
  logic [15:0] cur = 16'h0000, spd = 16'h0000;
  int          bad_count = 0, n_tests = 0;

  always #10 clk_i = ~clk_i;

  dfm_plant_model u_plant (.clk_i(clk_i), .cmd_i(cmd), .travel_i(trav), .open_i(opn),
    .stuck_i(stk), .regen_open_i(ropen), .regen_fail_i(rfail), .feedback_o(fb),
    .regen_closed_o(rcl), .regen_active_o(ract));

  dfm_monitor #(.CYC_PER_MS(MS), .VX_MS(3), .STILL_MS(5), .REGEN_MS(3)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wd), .wb_sel_i(4'hF),
    .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdo), .wb_ack_o(ack),
    .contactor_feedback_first_i(fb[0]), .contactor_feedback_second_i(fb[1]),
    .contactors_commanded_i(cmd), .travel_active_i(trav), .travel_cmd_i(tcmd),
    .drive_release_signal_i(rel), .readjust_i(readj), .motor_current_i(cur),
    .actual_speed_i(spd), .drive_operating_i(oper), .regen_monitor_closed_i(rcl),
    .regen_active_i(ract), .drive_status_output_one_o(out1),
    .drive_status_output_two_o(out2), .locked_o(lck), .irq_o(irq));

  task automatic conclude();
    $display("checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      bad_count++;
    end
  endtask

  task automatic bus(input logic [7:0] a, input logic [31:0] d, input logic w);
    int n;
    adr <= a;
    wd  <= d;
    we  <= w;
    cyc <= 1'b1;
    stb <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rq = rdo;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge clk_i);
    if (n >= 20) begin
      $display("unexpected at %0t: bus timeout", $time);
      bad_count++;
      conclude();
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    bus(a, 32'h0000_0000, 1'b0);
    chk(rq & m, exp, "read");
  endtask

  task automatic wt(input int ms);
    repeat ((ms + 2) * MS + 8) @(posedge clk_i);
  endtask

  function automatic logic [31:0] ev(input logic [9:0] num, input logic [1:0] inf);
    return {1'b1, 17'h0_0000, inf, 2'b00, num};
  endfunction

  task automatic ack_err();
    bus(dfm_pkg::ADDR_ACK, 32'h0000_0000, 1'b1);
    rd(dfm_pkg::ADDR_ERR, 32'h8000_0000, 32'h0000_0000);
  endtask

  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(dfm_pkg::ADDR_CDLY, 32'hFFFF_FFFF, {16'h0000, dfm_pkg::CDLY_RESET});
    rd(dfm_pkg::ADDR_TMAX, 32'hFFFF_FFFF, {16'h0000, dfm_pkg::TMAX_RESET});
    bus(8'h3C, 32'hFFFF_FFFF, 1'b1);
    rd(8'h3C, 32'hFFFF_FFFF, 32'h0000_0000);
    bus(dfm_pkg::ADDR_CDLY, 32'h0000_0002, 1'b1);
    bus(dfm_pkg::ADDR_IRQ_EN, 32'h0000_0002, 1'b1);
    $display("test registers done");
    cmd <= 1'b1;
    opn <= 2'b11;
    wt(2);
    rd(dfm_pkg::ADDR_ERR, 32'hFFFF_FFFF, ev(dfm_pkg::ERR_CO_ON, 2'd3));
    rd(dfm_pkg::ADDR_ERR, 32'hFFFF_FFFF, ev(dfm_pkg::ERR_CO_ON, 2'd3));
    chk({31'h0, irq}, 32'h0000_0000, "masked irq");
    cmd <= 1'b0;
    opn <= 2'b00;
    ack_err();
    $display("test no feedback done");
    for (int v = 0; v < 2; v++) begin
      bus(dfm_pkg::ADDR_CTRL, v << 2, 1'b1);
      cmd  <= 1'b1;
      trav <= 1'b1;
      wt(2);
      opn <= 2'b01;
      repeat (10) @(posedge clk_i);
      rd(dfm_pkg::ADDR_ERR, 32'hFFFF_FFFF, ev(v ? 10'd546 : 10'd545, 2'd1));
      opn  <= 2'b00;
      trav <= 1'b0;
      cmd  <= 1'b0;
      wt(7);
      ack_err();
    end
    $display("test open early done");
    for (int i = 0; i < 2; i++) begin
      stk <= i ? 2'b10 : 2'b01;
      cmd <= 1'b1;
      repeat (8) @(posedge clk_i);
      cmd <= 1'b0;
      wt(7);
      rd(dfm_pkg::ADDR_ERR, 32'hFFFF_FFFF, ev(i ? 10'd549 : 10'd548, i ? 2'd2 : 2'd1));
      stk <= 2'b00;
      // The stuck contact must be gone before the acknowledge, or it latches again.
      repeat (2) @(posedge clk_i);
      ack_err();
    end
    $display("test still on done");
    rel  <= 1'b1;
    tcmd <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk({30'h0, out2, out1}, 32'h0000_0003, "status on");
    rel <= 1'b0;
    wt(3);
    rd(dfm_pkg::ADDR_ERR, 32'h8000_03FF, 32'h8000_0220);
    tcmd <= 1'b0;
    ack_err();
    $display("test travel command done");
    bus(dfm_pkg::ADDR_IMAX, 32'h0000_0064, 1'b1);
    bus(dfm_pkg::ADDR_TMAX, 32'h0000_0002, 1'b1);
    cur <= 16'h0064;
    wt(2);
    rd(dfm_pkg::ADDR_ERR, 32'h8000_0000, 32'h0000_0000);
    cur <= 16'h0065;
    wt(2);
    rd(dfm_pkg::ADDR_ERR, 32'h8000_03FF, 32'h8000_0226);
    cur <= 16'h0000;
    ack_err();
    $display("test overload done");
    oper  <= 1'b1;
    ropen <= 1'b1;
    repeat (6) @(posedge clk_i);
    rd(dfm_pkg::ADDR_STATUS, 32'h0000_0004, 32'h0000_0004);
    chk({31'h0, irq}, 32'h0000_0001, "regen irq");
    ropen <= 1'b0;
    repeat (6) @(posedge clk_i);
    rd(dfm_pkg::ADDR_STATUS, 32'h0000_0004, 32'h0000_0000);
    rd(dfm_pkg::ADDR_ERR, 32'h8000_0000, 32'h0000_0000);
    rd(dfm_pkg::ADDR_IRQ_STAT, 32'h0000_0007, 32'h0000_0003);
    bus(dfm_pkg::ADDR_IRQ_CLR, 32'h0000_0007, 1'b1);
    chk({31'h0, irq}, 32'h0000_0000, "irq cleared");
    rd(dfm_pkg::ADDR_IRQ_STAT, 32'h0000_0007, 32'h0000_0000);
    oper  <= 1'b0;
    rfail <= 1'b1;
    cmd   <= 1'b1;
    trav  <= 1'b1;
    wt(3);
    rd(dfm_pkg::ADDR_ERR, 32'h8000_03FF, 32'h8000_023B);
    trav  <= 1'b0;
    cmd   <= 1'b0;
    rfail <= 1'b0;
    wt(7);
    ack_err();
    $display("test feedback unit done");
    bus(dfm_pkg::ADDR_VZ, 32'h0000_0032, 1'b1);
    rel   <= 1'b1;
    readj <= 1'b1;
    spd   <= 16'h0064;
    repeat (10) @(posedge clk_i);
    rd(dfm_pkg::ADDR_ERR, 32'h8000_0000, 32'h0000_0000);
    bus(dfm_pkg::ADDR_CTRL, 32'h0000_1F01, 1'b1);
    rd(dfm_pkg::ADDR_CTRL, 32'h0000_FF07, 32'h0000_1F03);
    repeat (10) @(posedge clk_i);
    rd(dfm_pkg::ADDR_ERR, 32'h8000_03FF, 32'h8000_0230);
    chk({29'h0, lck, out2, out1}, 32'h0000_0004, "locked");
    rd(dfm_pkg::ADDR_STATUS, 32'h0000_0008, 32'h0000_0008);
    rst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk({31'h0, lck}, 32'h0000_0000, "lock after reset");
    $display("test readjust lock done");
    conclude();
  end
endmodule

bind dfm_monitor dfm_monitor_chk u_chk (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .wb_adr_i(wb_adr_i),
  .wb_we_i(wb_we_i),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o),
  .drive_release_signal_i(drive_release_signal_i),
  .drive_status_output_one_o(drive_status_output_one_o),
  .drive_status_output_two_o(drive_status_output_two_o),
  .locked_o(locked_o),
  .irq_o(irq_o)
);
